// ==== hdl/mic_irq_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.svh"
// Operation
// RULE1: Four maskable sources plus one non-maskable
// RULE2: NMI vector fetch at FFCh/FFDh
// RULE3: Port A uses vector 1 FF6h/FF7h
// RULE4: Ports B and C share vector 2
// RULE5: Timer vector 3, converter vector 4
// RULE6: Accepted request loads PC with vector
// RULE7: Peripheral request needs flag and mask
// RULE8: NMI preempts; maskables never nest
// RULE9: Fixed priority, vector 1 highest
// RULE10: Option register write-only at C8h
// RULE11: Level select: vector 1 low-level or falling
// RULE12: Edge select: vector 2 rising or falling
// RULE13: Global enable gates maskables only
// RULE14: Reset clears whole option register
// RULE15: NMI falling edge latch, cleared on entry
// RULE16: Edge mode stores one extra edge
// RULE17: Level source holds low when sampled
// RULE18: Sample at instruction end, then vector
// RULE19: NMI without global enable does not wake
// RULE20: Entry swaps flags, pushes PC, inhibits
// RULE21: Return restores flags and pops PC
// RULE22: Six twelve-bit shifting stack levels
// RULE23: Reset starts in NMI mode
// RULE24: Option bits 6,5,4 layout; others ignored
module mic_irq_ctrl (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Data space write port from the core
	input wire logic i_wr_en,
	input wire logic [7:0] i_wr_addr,
	input wire logic [7:0] i_wr_data,
	// Interrupt sources
	input wire logic i_nmi_n,
	input wire logic i_porta_line,
	input wire logic i_portbc_line,
	input wire logic i_timer_zero_flag,
	input wire logic i_timer_irq_mask,
	input wire logic i_adc_done_flag,
	input wire logic i_converter_irq_mask,
	// Core sequencing
	input wire logic i_instr_end,
	input wire logic i_return_from_interrupt,
	input wire logic [`MIC_PC_WIDTH-1:0] i_pc,
	input wire logic i_low_power,
	// Answers to the core
	output logic o_take,
	output logic [`MIC_PC_WIDTH-1:0] o_vector_pc,
	output logic [`MIC_PC_WIDTH-1:0] o_return_pc,
	output mic_pkg::mic_flagset_type o_flagset,
	output mic_pkg::mic_vector_type o_vector,
	output logic o_wake,
	output logic o_level_select_vec1,
	output logic o_edge_select_vec2,
	output logic o_global_irq_enable
);
	import mic_pkg::*;

	typedef struct packed {
		logic [7:0] interrupt_option;
		mic_flagset_type flagset;
		mic_flagset_type saved_flagset;
		logic in_nmi;
		logic in_irq;
		logic take;
		mic_vector_type vector;
		logic [`MIC_PC_WIDTH-1:0] vector_pc;
		logic wake;
	} mic_state_type;

	mic_state_type st, next_st;
	logic nmi_prev, next_nmi_prev;
	logic nmi_pend, next_nmi_pend;
	logic req_a, req_bc, req_tm, req_ad;
	logic clr_a, clr_bc, clr_nmi;
	logic push, pop;
	logic maskable_ok;
	mic_vector_type pick;
	logic [`MIC_PC_WIDTH-1:0] stack_top;

	// Vector address lookup
	function automatic logic [`MIC_PC_WIDTH-1:0] vec_addr(input mic_vector_type v);
		case (v)
			MIC_VEC_NMI: vec_addr = `MIC_VEC0_ADDR; // [RULE2]
			MIC_VEC_PORTA: vec_addr = `MIC_VEC1_ADDR; // [RULE3]
			MIC_VEC_PORTBC: vec_addr = `MIC_VEC2_ADDR; // [RULE4]
			MIC_VEC_TIMER: vec_addr = `MIC_VEC3_ADDR; // [RULE5]
			MIC_VEC_ADC: vec_addr = `MIC_VEC4_ADDR; // [RULE5]
			default: vec_addr = `MIC_RESET_VEC_ADDR;
		endcase
	endfunction : vec_addr

	// External input latches; vector 2 shares port B and C lines
	mic_edge_latch u_latch_a (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_line(i_porta_line),
		.i_rising(1'b0),
		.i_level(st.interrupt_option[`MIC_BIT_LEVEL_SELECT]), // [RULE11] [RULE17]
		.i_clear(clr_a),
		.o_req(req_a)
	);
	mic_edge_latch u_latch_bc (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_line(i_portbc_line),
		.i_rising(st.interrupt_option[`MIC_BIT_EDGE_SELECT]), // [RULE12]
		.i_level(1'b0),
		.i_clear(clr_bc),
		.o_req(req_bc)
	);

	// Return address stack
	mic_ret_stack #(
		.DEPTH(`MIC_STACK_DEPTH),
		.WIDTH(`MIC_PC_WIDTH)
	) u_stack (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_push(push),
		.i_pop(pop),
		.i_data(i_pc),
		.o_top(stack_top)
	); // [RULE22]

	// Peripheral requests need flag and mask
	assign req_tm = i_timer_zero_flag & i_timer_irq_mask; // [RULE7]
	assign req_ad = i_adc_done_flag & i_converter_irq_mask; // [RULE7]

	// Maskables allowed only with enable and no routine running
	assign maskable_ok = st.interrupt_option[`MIC_BIT_GLOBAL_ENABLE] & ~st.in_irq & ~st.in_nmi; // [RULE8] [RULE13]

	// Priority pick: NMI, then vectors 1 to 4
	always_comb begin
		pick = MIC_VEC_NONE;
		if (nmi_pend) begin
			pick = MIC_VEC_NMI; // [RULE8]
		end else if (maskable_ok && req_a) begin
			pick = MIC_VEC_PORTA; // [RULE9]
		end else if (maskable_ok && req_bc) begin
			pick = MIC_VEC_PORTBC;
		end else if (maskable_ok && req_tm) begin
			pick = MIC_VEC_TIMER;
		end else if (maskable_ok && req_ad) begin
			pick = MIC_VEC_ADC; // [RULE1]
		end
	end

	// Entry and return strobes
	assign push = i_instr_end & (pick != MIC_VEC_NONE); // [RULE18] [RULE20]
	assign pop = i_return_from_interrupt & ~push; // [RULE21]
	assign clr_nmi = push & (pick == MIC_VEC_NMI); // [RULE15]
	assign clr_a = push & (pick == MIC_VEC_PORTA); // [RULE20]
	assign clr_bc = push & (pick == MIC_VEC_PORTBC); // [RULE16]

	// NMI falling edge latch, set wins over clear
	always_comb begin
		next_nmi_prev = i_nmi_n;
		next_nmi_pend = nmi_pend;
		if (nmi_prev && !i_nmi_n) begin
			next_nmi_pend = 1'b1; // [RULE15]
		end else if (clr_nmi) begin
			next_nmi_pend = 1'b0;
		end
	end

	// Next state of the controller
	always_comb begin
		next_st = st;
		next_st.take = 1'b0;
		next_st.wake = 1'b0;
		// Write-only option register; unused bits dropped
		if (i_wr_en && i_wr_addr == `MIC_OPTION_ADDR) begin // [RULE10]
			next_st.interrupt_option = i_wr_data & 8'h70; // [RULE24]
		end
		if (push) begin
			next_st.take = 1'b1; // [RULE6]
			next_st.vector = pick;
			next_st.vector_pc = vec_addr(pick);
			next_st.saved_flagset = st.flagset;
			if (pick == MIC_VEC_NMI) begin
				next_st.flagset = MIC_FLAGS_NMI; // [RULE20]
				next_st.in_nmi = 1'b1;
			end else begin
				next_st.flagset = MIC_FLAGS_IRQ;
				next_st.in_irq = 1'b1;
			end
		end else if (pop) begin
			// Leave NMI first, then the maskable routine
			if (st.in_nmi) begin
				next_st.in_nmi = 1'b0;
				next_st.flagset = st.in_irq ? MIC_FLAGS_IRQ : MIC_FLAGS_NORMAL; // [RULE21]
			end else begin
				next_st.in_irq = 1'b0;
				next_st.flagset = MIC_FLAGS_NORMAL;
			end
		end
		// Wake from low power: NMI only with global enable
		if (i_low_power && pick != MIC_VEC_NONE) begin
			next_st.wake = (pick != MIC_VEC_NMI) | st.interrupt_option[`MIC_BIT_GLOBAL_ENABLE]; // [RULE19]
		end
	end

	// Registers; reset enters NMI mode with option cleared
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st <= '{interrupt_option: `MIC_OPTION_RESET, // [RULE14]
				flagset: MIC_FLAGS_NMI, saved_flagset: MIC_FLAGS_NORMAL,
				in_nmi: 1'b1, in_irq: 1'b0, take: 1'b0, vector: MIC_VEC_NONE,
				vector_pc: `MIC_RESET_VEC_ADDR, wake: 1'b0}; // [RULE23]
			nmi_prev <= 1'b1;
			nmi_pend <= 1'b0;
		end else begin
			st <= next_st;
			nmi_prev <= next_nmi_prev;
			nmi_pend <= next_nmi_pend;
		end
	end

	// Outputs straight from flip-flops
	assign o_take = st.take;
	assign o_vector_pc = st.vector_pc;
	assign o_return_pc = stack_top;
	assign o_flagset = st.flagset;
	assign o_vector = st.vector;
	assign o_wake = st.wake;
	assign o_level_select_vec1 = st.interrupt_option[`MIC_BIT_LEVEL_SELECT];
	assign o_edge_select_vec2 = st.interrupt_option[`MIC_BIT_EDGE_SELECT];
	assign o_global_irq_enable = st.interrupt_option[`MIC_BIT_GLOBAL_ENABLE];

	// Checks
	a_nmi_vector: assert property (@(posedge i_clk) disable iff (i_srst)
		clr_nmi |=> (o_take && o_vector_pc == 12'hffc)) // [RULE2]
		else $error("NMI vector wrong");
	a_porta_vector: assert property (@(posedge i_clk) disable iff (i_srst)
		clr_a |=> (o_vector_pc == 12'hff6)) // [RULE3]
		else $error("port A vector wrong");
	a_bc_vector: assert property (@(posedge i_clk) disable iff (i_srst)
		clr_bc |=> (o_vector_pc == 12'hff4)) // [RULE4]
		else $error("port B/C vector wrong");
	a_no_nesting: assert property (@(posedge i_clk) disable iff (i_srst)
		(st.in_irq && push) |-> pick == MIC_VEC_NMI) // [RULE8]
		else $error("maskable nested");
	a_gen_gates: assert property (@(posedge i_clk) disable iff (i_srst)
		(!o_global_irq_enable && push) |-> pick == MIC_VEC_NMI) // [RULE13]
		else $error("maskable taken while disabled");
	a_priority_one: assert property (@(posedge i_clk) disable iff (i_srst)
		(push && req_a && maskable_ok && !nmi_pend) |=> o_vector == MIC_VEC_PORTA) // [RULE9]
		else $error("priority broken");
	a_periph_mask: assert property (@(posedge i_clk) disable iff (i_srst)
		(push && pick == MIC_VEC_TIMER) |-> (i_timer_zero_flag && i_timer_irq_mask)) // [RULE7]
		else $error("timer unmasked");
	a_entry_flags: assert property (@(posedge i_clk) disable iff (i_srst)
		(push && pick != MIC_VEC_NMI) |=> (o_flagset == MIC_FLAGS_IRQ && st.in_irq)) // [RULE20]
		else $error("flag swap missing");
	a_stack_push: assert property (@(posedge i_clk) disable iff (i_srst)
		push |=> o_return_pc == $past(i_pc)) // [RULE22]
		else $error("PC not stacked");
	a_take_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
		o_take |=> !o_take || $past(push)) // [RULE18]
		else $error("take stuck");
	c_nmi_taken: cover property (@(posedge i_clk) clr_nmi);
	c_timer_taken: cover property (@(posedge i_clk) push && pick == MIC_VEC_TIMER);
	c_nmi_nests: cover property (@(posedge i_clk) st.in_irq && clr_nmi);
	c_return: cover property (@(posedge i_clk) pop && st.in_irq);
	c_porta_level: cover property (@(posedge i_clk) clr_a && o_level_select_vec1);

	// Peripheral vectors and converter masking
	a_adc_mask: assert property (@(posedge i_clk) disable iff (i_srst)
		(push && pick == MIC_VEC_ADC) |-> (i_adc_done_flag && i_converter_irq_mask)) // [RULE7]
		else $error("converter unmasked");
	a_timer_vector: assert property (@(posedge i_clk) disable iff (i_srst)
		(push && pick == MIC_VEC_TIMER) |=> (o_vector_pc == 12'hff2)) // [RULE5]
		else $error("timer vector wrong");
	a_adc_vector: assert property (@(posedge i_clk) disable iff (i_srst)
		(push && pick == MIC_VEC_ADC) |=> (o_vector_pc == 12'hff0)) // [RULE5]
		else $error("converter vector wrong");

	// Return, wake gating, option write and NMI latch
	a_return_flags: assert property (@(posedge i_clk) disable iff (i_srst)
		(pop && !st.in_nmi) |=> (o_flagset == MIC_FLAGS_NORMAL)) // [RULE21]
		else $error("flags not restored");
	a_nmi_wake: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_low_power && pick == MIC_VEC_NMI && !o_global_irq_enable) |=> !o_wake) // [RULE19]
		else $error("NMI woke while disabled");
	a_option_write: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_wr_en && i_wr_addr == `MIC_OPTION_ADDR) |=> (o_global_irq_enable == $past(i_wr_data[`MIC_BIT_GLOBAL_ENABLE]))) // [RULE10]
		else $error("option write lost");
	a_nmi_latch: assert property (@(posedge i_clk) disable iff (i_srst)
		(nmi_prev && !i_nmi_n) |=> nmi_pend) // [RULE15]
		else $error("NMI edge not latched");
endmodule : mic_irq_ctrl
`default_nettype wire

// ==== hdl/mic_consts.svh ====
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
// Data space address of the write-only option register
`define MIC_OPTION_ADDR 8'hc8
// Option register fields
`define MIC_BIT_LEVEL_SELECT 6
`define MIC_BIT_EDGE_SELECT 5
`define MIC_BIT_GLOBAL_ENABLE 4
`define MIC_OPTION_RESET 8'h00
// Vector entry addresses (low byte of each pair)
`define MIC_VEC0_ADDR 12'hffc
`define MIC_VEC1_ADDR 12'hff6
`define MIC_VEC2_ADDR 12'hff4
`define MIC_VEC3_ADDR 12'hff2
`define MIC_VEC4_ADDR 12'hff0
`define MIC_RESET_VEC_ADDR 12'hffe
// Stack geometry
`define MIC_STACK_DEPTH 6
`define MIC_PC_WIDTH 12
`endif

// ==== hdl/mic_pkg.sv ====
package mic_pkg;
	// Flag set in use by the core
	typedef enum logic [1:0] {
		MIC_FLAGS_NORMAL,
		MIC_FLAGS_IRQ,
		MIC_FLAGS_NMI
	} mic_flagset_type;
	// Vector numbers
	typedef enum logic [2:0] {
		MIC_VEC_NMI,
		MIC_VEC_PORTA,
		MIC_VEC_PORTBC,
		MIC_VEC_TIMER,
		MIC_VEC_ADC,
		MIC_VEC_NONE
	} mic_vector_type;
endpackage : mic_pkg

// ==== hdl/mic_edge_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.svh"
// One-deep edge latch with polarity select, optional level mode
module mic_edge_latch (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Line and mode
	input wire logic i_line,
	input wire logic i_rising,
	input wire logic i_level,
	// Clear from the core at vector entry
	input wire logic i_clear,
	// Request out
	output logic o_req
);
	typedef struct packed {
		logic prev;
		logic pend;
	} mic_el_state_type;
	mic_el_state_type st, next_st;
	logic edge_seen;

	// Edge detect, latch one event, set wins over clear
	always_comb begin
		next_st = st;
		edge_seen = i_rising ? (i_line & ~st.prev) : (~i_line & st.prev);
		next_st.prev = i_line;
		if (i_level) begin
			next_st.pend = 1'b0;
		end else if (edge_seen) begin
			next_st.pend = 1'b1;
		end else if (i_clear) begin
			next_st.pend = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st <= '{prev: 1'b1, pend: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// Level mode: no storage, line low requests
	assign o_req = i_level ? ~i_line : st.pend;

	a_latch_set: assert property (@(posedge i_clk) disable iff (i_srst)
		(!i_level && edge_seen) |=> st.pend)
		else $error("edge not latched");
endmodule : mic_edge_latch
`default_nettype wire

// ==== hdl/mic_ret_stack.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.svh"
// Shift-register return stack, no pointer
module mic_ret_stack #(
	parameter int DEPTH = `MIC_STACK_DEPTH,
	parameter int WIDTH = `MIC_PC_WIDTH
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Push and pop
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [WIDTH-1:0] i_data,
	// Top of stack
	output logic [WIDTH-1:0] o_top
);
	logic [WIDTH-1:0] lvl [DEPTH];

	// Each level shifts with its neighbour; deepest drops on push
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_lvl
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					lvl[g] <= '0;
				end else if (i_push) begin
					lvl[g] <= (g == 0) ? i_data : lvl[(g == 0) ? 0 : g-1];
				end else if (i_pop) begin
					lvl[g] <= (g == DEPTH-1) ? lvl[g] : lvl[(g == DEPTH-1) ? g : g+1];
				end
			end
		end
	endgenerate

	assign o_top = lvl[0];
endmodule : mic_ret_stack
`default_nettype wire

// ==== sim/mic_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Core model: one instruction every four cycles, a return when asked
module mic_core_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Bench requests
	input wire logic i_ret_req,
	input wire logic [11:0] i_step,
	// Core sequencing toward the controller
	output logic o_instr_end,
	output logic o_return_from_interrupt,
	output logic [11:0] o_pc,
	output logic [11:0] o_last_pc
);
	logic [1:0] cnt = 2'h0;
	logic ret_pend = 1'b0;
	// Known levels before the first falling edge
	initial begin
		o_pc = 12'h100;
		o_instr_end = 1'b0;
		o_return_from_interrupt = 1'b0;
	end
	// Signals move just after the falling edge, never near the sampling edge
	always @(negedge i_clk) begin
		cnt <= i_srst ? 2'h0 : cnt + 2'h1;
		o_instr_end <= !i_srst && cnt == 2'h3;
		o_return_from_interrupt <= !i_srst && ret_pend && cnt == 2'h1;
		ret_pend <= !i_srst && (i_ret_req || (ret_pend && cnt != 2'h1));
		if (o_instr_end) begin
			o_pc <= o_pc + i_step;
		end
		if (cnt == 2'h3) begin
			o_last_pc <= o_pc;
		end
	end
endmodule : mic_core_model
`default_nettype wire

// ==== sim/mic_irq_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_consts.svh"
module mic_irq_ctrl_tb;
	import mic_pkg::*;
	logic i_clk, i_srst, wr_en, nmi_n, porta, pbc, tmr_f, tmr_m, adc_f, adc_m, low_power, ret_req, woke;
	logic instr_end, rfi, take, wake, level_select_vec1, edge_select_vec2, gen;
	logic [7:0] wr_addr, wr_data, d;
	logic [11:0] step, pc, last_pc, vpc, rpc, p1;
	mic_flagset_type flags;
	mic_vector_type vec;
	int seed, error_cnt, num_checks;
	mic_irq_ctrl uut (.i_clk(i_clk), .i_srst(i_srst), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
		.i_nmi_n(nmi_n), .i_porta_line(porta), .i_portbc_line(pbc), .i_timer_zero_flag(tmr_f),
		.i_timer_irq_mask(tmr_m), .i_adc_done_flag(adc_f), .i_converter_irq_mask(adc_m), .i_instr_end(instr_end),
		.i_return_from_interrupt(rfi), .i_pc(pc), .i_low_power(low_power), .o_take(take), .o_vector_pc(vpc),
		.o_return_pc(rpc), .o_flagset(flags), .o_vector(vec), .o_wake(wake), .o_level_select_vec1(level_select_vec1),
		.o_edge_select_vec2(edge_select_vec2), .o_global_irq_enable(gen));
	mic_core_model core (.i_clk(i_clk), .i_srst(i_srst), .i_ret_req(ret_req), .i_step(step),
		.o_instr_end(instr_end), .o_return_from_interrupt(rfi), .o_pc(pc), .o_last_pc(last_pc));
	// Clock, 50 ns period
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// Remember any wake request
	always @(posedge i_clk) begin
		if (i_srst || !low_power) woke <= 1'b0;
		else if (wake === 1'b1) woke <= 1'b1;
	end
	task automatic chk_bit(string n, logic e, logic s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk_bit
	task automatic chk_pc(string n, logic [11:0] e, logic [11:0] s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk_pc
	task automatic chk_vec(string n, mic_vector_type e, mic_vector_type s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk_vec
	task automatic chk_flag(string n, mic_flagset_type e, mic_flagset_type s);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk_flag
	// Vector entry address expected for a vector number
	function automatic logic [11:0] exp_pc(mic_vector_type v);
		case (v)
			MIC_VEC_NMI: return `MIC_VEC0_ADDR;
			MIC_VEC_PORTA: return `MIC_VEC1_ADDR;
			MIC_VEC_PORTBC: return `MIC_VEC2_ADDR;
			MIC_VEC_TIMER: return `MIC_VEC3_ADDR;
			default: return `MIC_VEC4_ADDR;
		endcase
	endfunction : exp_pc
	task automatic wr(logic [7:0] a, logic [7:0] v);
		@(negedge i_clk) {wr_en, wr_addr, wr_data} = {1'b1, a, v};
		@(negedge i_clk) wr_en = 1'b0;
	endtask : wr
	// Wait for an entry; vector NONE means none may come
	task automatic serve(mic_vector_type v);
		logic got;
		got = 1'b0;
		step = 12'($random(seed));
		for (int k = 0; k < 40 && !got; k++) begin
			@(posedge i_clk);
			#1 got = take;
		end
		chk_bit("take", v != MIC_VEC_NONE, got);
		if (got) begin
			chk_vec("vec", v, vec);
			chk_pc("vpc", exp_pc(v), vpc);
			chk_pc("stack", last_pc, rpc);
			chk_flag("flags", v == MIC_VEC_NMI ? MIC_FLAGS_NMI : MIC_FLAGS_IRQ, flags);
		end
		@(negedge i_clk);
	endtask : serve
	task automatic ret();
		logic seen;
		seen = 1'b0;
		@(negedge i_clk) ret_req <= 1'b1;
		@(negedge i_clk) ret_req <= 1'b0;
		for (int k = 0; k < 8 && !seen; k++) begin
			@(posedge i_clk);
			#1 seen = rfi;
		end
		@(negedge i_clk);
	endtask : ret
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	// Cut a hang short
	initial begin
		repeat (6000) @(posedge i_clk);
		error_cnt++;
		close_out();
	end
	// Main sequence
	initial begin
		seed = 9;
		{wr_en, wr_addr, wr_data, tmr_f, tmr_m, adc_f, adc_m, low_power, ret_req} = '0;
		{nmi_n, porta, pbc, i_srst, step} = {4'hf, 12'h001};
		repeat (12) @(posedge i_clk);
		@(negedge i_clk) i_srst = 1'b0;
		chk_bit("opt", 1'b0, level_select_vec1 | edge_select_vec2 | gen);
		chk_flag("rst", MIC_FLAGS_NMI, flags);
		chk_pc("rvec", `MIC_RESET_VEC_ADDR, vpc);
		d = 8'($random(seed));
		wr(8'hc9 + {5'h00, d[2:0]}, 8'hff);
		chk_bit("other", 1'b0, gen);
		wr(`MIC_OPTION_ADDR, d);
		chk_bit("les", d[6], level_select_vec1);
		chk_bit("esb", d[5], edge_select_vec2);
		chk_bit("gen", d[4], gen);
		wr(`MIC_OPTION_ADDR, 8'h10 | (d & 8'h8f));
		{tmr_f, tmr_m} = 2'h3;
		serve(MIC_VEC_NONE);
		ret();
		serve(MIC_VEC_TIMER);
		p1 = last_pc;
		tmr_f = 1'b0;
		@(negedge i_clk) porta = 1'b0;
		@(negedge i_clk) porta = 1'b1;
		@(negedge i_clk) porta = 1'b0;
		serve(MIC_VEC_NONE);
		nmi_n = 1'b0;
		serve(MIC_VEC_NMI);
		ret();
		chk_flag("back", MIC_FLAGS_IRQ, flags);
		chk_pc("pop", p1, rpc);
		ret();
		serve(MIC_VEC_PORTA);
		porta = 1'b1;
		ret();
		serve(MIC_VEC_NONE);
		adc_f = 1'b1;
		serve(MIC_VEC_NONE);
		wr(`MIC_OPTION_ADDR, 8'h00);
		{tmr_f, adc_m} = 2'h3;
		serve(MIC_VEC_NONE);
		wr(`MIC_OPTION_ADDR, 8'h10);
		serve(MIC_VEC_TIMER);
		tmr_f = 1'b0;
		ret();
		serve(MIC_VEC_ADC);
		adc_f = 1'b0;
		ret();
		pbc = 1'b0;
		serve(MIC_VEC_PORTBC);
		ret();
		wr(`MIC_OPTION_ADDR, 8'h30);
		pbc = 1'b1;
		serve(MIC_VEC_PORTBC);
		ret();
		wr(`MIC_OPTION_ADDR, 8'h50);
		porta = 1'b0;
		serve(MIC_VEC_PORTA);
		ret();
		serve(MIC_VEC_PORTA);
		porta = 1'b1;
		ret();
		serve(MIC_VEC_NONE);
		wr(`MIC_OPTION_ADDR, 8'h00);
		{low_power, nmi_n} = 2'h3;
		@(negedge i_clk) nmi_n = 1'b0;
		serve(MIC_VEC_NMI);
		chk_bit("wake", 1'b0, woke);
		low_power = 1'b0;
		close_out();
	end
endmodule : mic_irq_ctrl_tb
`default_nettype wire
